// file: core/spi_memory_slave_frontend.sv
// Serial slave front end: frames, shifts, decodes and answers status reads.
// Assumes clk is much faster than the link clock (125 MHz against 12.5 MHz).
`timescale 1ns/1ps
module spi_memory_slave_frontend (
    // System clock and reset.
    input wire logic clk,
    input wire logic nrst,
    // Link pins, asynchronous to clk.
    input wire logic sel_n,
    input wire logic sclk,
    input wire logic sdi,
    // Serial output as data and enable.
    output logic sdo,
    output logic sdo_oe,
    // Command report to the memory side.
    output spi_front_pkg::cmd_report_t report,
    output logic cmd_valid,
    output logic addr_valid,
    output logic data_valid,
    // Status byte as held here; bits 2, 3 and 7 come from outside.
    input wire logic [7:0] status_ext,
    output logic write_enable_flag,
    output logic mode3
);
    import spi_front_pkg::*;

    // Two-stage synchronisers; only the second stage is read.
    logic [2:0] sync1_q;
    logic [2:0] sync2_q;
    // Previous samples for edge detection.
    logic sclk_prev_q;
    logic sel_prev_q;

    // Synchronise the three pins.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            // Select high, clock and data low, matching the edge history below,
            // so no false clock edge follows reset.
            sync1_q <= 3'h4;
            sync2_q <= 3'h4;
            sclk_prev_q <= 1'b0;
            sel_prev_q <= 1'b1;
        end else begin
            sync1_q <= {sel_n, sclk, sdi};
            sync2_q <= sync1_q;
            sclk_prev_q <= sync2_q[1];
            sel_prev_q <= sync2_q[2];
        end
    end

    // Synchronised levels and edges of the link.
    logic sel_s;
    logic sclk_s;
    logic sdi_s;
    logic rise;
    logic fall;
    logic sel_fall;
    logic sel_rise;
    assign sel_s = sync2_q[2];
    assign sclk_s = sync2_q[1];
    assign sdi_s = sync2_q[0];
    assign rise = sclk_s && !sclk_prev_q;
    assign fall = !sclk_s && sclk_prev_q;
    assign sel_fall = !sel_s && sel_prev_q;
    assign sel_rise = sel_s && !sel_prev_q;

    // Frame state and shift registers.
    frame_state_t state_q, state_d;
    logic [7:0] shift_q, shift_d;
    logic [2:0] bit_q, bit_d;
    logic [4:0] abyte_q, abyte_d;
    logic armed_q, armed_d;
    logic mode3_q, mode3_d;
    cmd_t cmd_q, cmd_d;
    logic [ADDR_BITS-1:0] addr_q, addr_d;
    logic [7:0] data_q, data_d;
    logic cv_d, av_d, dv_d;
    logic cv_q, av_q, dv_q;
    // Read-back shifter and output drive.
    logic [7:0] tx_q, tx_d;
    logic sdo_q, sdo_d;
    logic oe_q, oe_d;
    logic wel_q, wel_d;
    // Decoder outputs for the byte just completed.
    logic [7:0] byte_now;
    cmd_t dec_cmd;
    logic dec_valid;

    assign byte_now = {shift_q[6:0], sdi_s};

    spi_opcode_decode u_decode (
        .opcode(byte_now),
        .cmd(dec_cmd),
        .valid(dec_valid)
    );

    // Next-state logic for framing, shifting and the output.
    always_comb begin
        state_d = state_q;
        shift_d = shift_q;
        bit_d = bit_q;
        abyte_d = abyte_q;
        armed_d = armed_q;
        mode3_d = mode3_q;
        cmd_d = cmd_q;
        addr_d = addr_q;
        data_d = data_q;
        tx_d = tx_q;
        sdo_d = sdo_q;
        oe_d = oe_q;
        wel_d = wel_q;
        cv_d = 1'b0;
        av_d = 1'b0;
        dv_d = 1'b0;
        if (sel_fall) begin
            // Clock level at selection picks the mode.
            mode3_d = sclk_s;
            // In mode 3 wait for the clock to fall before counting rises.
            armed_d = !sclk_s;
            state_d = ST_OPCODE;
            bit_d = 3'h0;
            abyte_d = 5'h0;
            cmd_d = CMD_NONE;
            oe_d = 1'b0;
        end else if (sel_s) begin
            // Deselected: drop any partial command and float the output.
            if (sel_rise) begin
                // Write-class commands close the latch on deselect.
                case (cmd_q)
                    CMD_LATCH_CLEAR, CMD_STATUS_WRITE, CMD_MEM_WRITE,
                    CMD_SPECIAL_WRITE, CMD_SERIAL_WRITE: wel_d = 1'b0;
                    default: wel_d = wel_q;
                endcase
            end
            state_d = ST_IDLE;
            oe_d = 1'b0;
        end else begin
            if (fall) begin
                armed_d = 1'b1;
                // Output changes only on falling edges.
                if (oe_q) begin
                    sdo_d = tx_q[7];
                    tx_d = {tx_q[6:0], 1'b0};
                end
            end
            if (rise && armed_q && state_q != ST_IDLE && state_q != ST_IGNORE) begin
                // Capture on rising edges only, after selection.
                shift_d = byte_now;
                bit_d = bit_q + 3'h1;
                if (bit_q == LAST_BIT) begin
                    case (state_q)
                        ST_OPCODE: begin
                            // Eighth bit completes the opcode.
                            cmd_d = dec_cmd;
                            cv_d = dec_valid;
                            if (!dec_valid) begin
                                state_d = ST_IGNORE;
                            end else if (dec_cmd == CMD_LATCH_SET) begin
                                wel_d = 1'b1;
                                state_d = ST_DATA;
                            end else if (dec_cmd == CMD_STATUS_READ) begin
                                // Load the status byte and enable now; bits shift out from the next fall.
                                tx_d = (status_ext & 8'h8C) | STATUS_FIXED
                                    | (8'(wel_q) << STATUS_FLAG_POS);
                                oe_d = 1'b1;
                                state_d = ST_DATA;
                            end else if (dec_cmd == CMD_MEM_READ
                                || dec_cmd == CMD_MEM_WRITE
                                || dec_cmd == CMD_FAST_READ) begin
                                state_d = ST_ADDR;
                            end else begin
                                state_d = ST_DATA;
                            end
                        end
                        ST_ADDR: begin
                            // Keep the low 19 bits of the three bytes.
                            addr_d = ADDR_BITS'({addr_q, byte_now});
                            abyte_d = abyte_q + 5'h1;
                            if (abyte_q == ADDR_BYTES - 5'h1) begin
                                av_d = 1'b1;
                                state_d = ST_DATA;
                            end
                        end
                        ST_DATA: begin
                            data_d = byte_now;
                            dv_d = 1'b1;
                        end
                        default: state_d = ST_IGNORE;
                    endcase
                end
            end
        end
    end

    // Registers of the frame logic.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_q <= ST_IDLE;
            shift_q <= 8'h00;
            bit_q <= 3'h0;
            abyte_q <= 5'h00;
            armed_q <= 1'b0;
            mode3_q <= 1'b0;
            cmd_q <= CMD_NONE;
            addr_q <= '0;
            data_q <= 8'h00;
            tx_q <= 8'h00;
            sdo_q <= 1'b0;
            oe_q <= 1'b0;
            wel_q <= STATUS_RESET[STATUS_FLAG_POS];
            cv_q <= 1'b0;
            av_q <= 1'b0;
            dv_q <= 1'b0;
        end else begin
            state_q <= state_d;
            shift_q <= shift_d;
            bit_q <= bit_d;
            abyte_q <= abyte_d;
            armed_q <= armed_d;
            mode3_q <= mode3_d;
            cmd_q <= cmd_d;
            addr_q <= addr_d;
            data_q <= data_d;
            tx_q <= tx_d;
            sdo_q <= sdo_d;
            oe_q <= oe_d;
            wel_q <= wel_d;
            cv_q <= cv_d;
            av_q <= av_d;
            dv_q <= dv_d;
        end
    end

    // The device only answers; it never drives without selection.
    assign sdo = sdo_q;
    assign sdo_oe = oe_q;
    assign report = '{cmd: cmd_q, addr: addr_q, data: data_q};
    assign cmd_valid = cv_q;
    assign addr_valid = av_q;
    assign data_valid = dv_q;
    assign write_enable_flag = wel_q;
    assign mode3 = mode3_q;
endmodule

// file: core/spi_front_pkg.sv
// Constants, command codes and carrier types for the serial memory front end.
// Assumes a single system clock; the link clock is sampled like any pin.
// Summary of operation
// - Deselected: ignore input, output tristated
// - Capture on rising, drive on falling
// - Select samples clock level: mode choice
// - Mode 3: first rise after toggle
// - All bytes most significant bit first
// - Three address bytes, keep low 19
// - First full byte is the opcode
// - Unknown opcode: ignore until reselect
// - Decode latch set and clear
// - Decode status read and write
// - Decode memory write, read, fast read
// - Fifteen opcodes recognised in total
// - Low power opcodes; others invalid
// - Never initiate; master clock paces all
// - Drive output only returning read data
// - Write commands clear flag at deselect
package spi_front_pkg;

    // Opcode values.
    localparam logic [7:0] OP_LATCH_SET = 8'h06;
    localparam logic [7:0] OP_LATCH_CLEAR = 8'h04;
    localparam logic [7:0] OP_STATUS_READ = 8'h05;
    localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
    localparam logic [7:0] OP_MEM_WRITE = 8'h02;
    localparam logic [7:0] OP_MEM_READ = 8'h03;
    localparam logic [7:0] OP_FAST_READ = 8'h0B;
    localparam logic [7:0] OP_SPECIAL_WRITE = 8'h42;
    localparam logic [7:0] OP_SPECIAL_READ = 8'h4B;
    localparam logic [7:0] OP_DEVICE_ID_READ = 8'h9F;
    localparam logic [7:0] OP_UNIQUE_ID_READ = 8'h4C;
    localparam logic [7:0] OP_SERIAL_WRITE = 8'hC2;
    localparam logic [7:0] OP_SERIAL_READ = 8'hC3;
    localparam logic [7:0] OP_DEEP_SLEEP = 8'hBA;
    localparam logic [7:0] OP_HIBERNATE = 8'hB9;

    // Field sizes and counts.
    localparam int ADDR_BITS = 19;
    localparam logic [4:0] ADDR_BYTES = 5'h3;
    localparam logic [2:0] LAST_BIT = 3'h7;
    // Fixed status bits: bit 6 reads one, bits 0, 4 and 5 read zero.
    localparam logic [7:0] STATUS_FIXED = 8'h40;
    localparam int STATUS_FLAG_POS = 1;
    localparam logic [7:0] STATUS_RESET = 8'h00;

    // Decoded command classes.
    typedef enum logic [3:0] {
        CMD_NONE = 4'h0,
        CMD_LATCH_SET = 4'h1,
        CMD_LATCH_CLEAR = 4'h2,
        CMD_STATUS_READ = 4'h3,
        CMD_STATUS_WRITE = 4'h4,
        CMD_MEM_WRITE = 4'h5,
        CMD_MEM_READ = 4'h6,
        CMD_FAST_READ = 4'h7,
        CMD_SPECIAL_WRITE = 4'h8,
        CMD_SPECIAL_READ = 4'h9,
        CMD_DEVICE_ID_READ = 4'hA,
        CMD_UNIQUE_ID_READ = 4'hB,
        CMD_SERIAL_WRITE = 4'hC,
        CMD_SERIAL_READ = 4'hD,
        CMD_DEEP_SLEEP = 4'hE,
        CMD_HIBERNATE = 4'hF
    } cmd_t;

    // Frame states.
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_OPCODE = 3'h1,
        ST_ADDR = 3'h2,
        ST_DATA = 3'h3,
        ST_IGNORE = 3'h4
    } frame_state_t;

    // Command report handed to the command logic.
    typedef struct packed {
        cmd_t cmd;
        logic [ADDR_BITS-1:0] addr;
        logic [7:0] data;
    } cmd_report_t;

    // Serial output pin as data and enable.
    typedef struct packed {
        logic data;
        logic enable;
    } pin_out_t;

endpackage

// file: core/spi_opcode_decode.sv
// Opcode decoder: maps a received byte to a command class.
// Assumes a full byte is presented; purely combinational.
`timescale 1ns/1ps
module spi_opcode_decode (
    // Received byte.
    input wire logic [7:0] opcode,
    // Decoded class and validity.
    output spi_front_pkg::cmd_t cmd,
    output logic valid
);
    import spi_front_pkg::*;

    // Fifteen codes are recognised; the rest fall to invalid.
    always_comb begin
        valid = 1'b1;
        case (opcode)
            OP_LATCH_SET: cmd = CMD_LATCH_SET;
            OP_LATCH_CLEAR: cmd = CMD_LATCH_CLEAR;
            OP_STATUS_READ: cmd = CMD_STATUS_READ;
            OP_STATUS_WRITE: cmd = CMD_STATUS_WRITE;
            OP_MEM_WRITE: cmd = CMD_MEM_WRITE;
            OP_MEM_READ: cmd = CMD_MEM_READ;
            OP_FAST_READ: cmd = CMD_FAST_READ;
            OP_SPECIAL_WRITE: cmd = CMD_SPECIAL_WRITE;
            OP_SPECIAL_READ: cmd = CMD_SPECIAL_READ;
            OP_DEVICE_ID_READ: cmd = CMD_DEVICE_ID_READ;
            OP_UNIQUE_ID_READ: cmd = CMD_UNIQUE_ID_READ;
            OP_SERIAL_WRITE: cmd = CMD_SERIAL_WRITE;
            OP_SERIAL_READ: cmd = CMD_SERIAL_READ;
            OP_DEEP_SLEEP: cmd = CMD_DEEP_SLEEP;
            OP_HIBERNATE: cmd = CMD_HIBERNATE;
            default: begin
                // Reserved codes are treated as invalid.
                cmd = CMD_NONE;
                valid = 1'b0;
            end
        endcase
    end
endmodule

// file: test/spi_front_sva.sv
// Checker for the serial memory front end, bound to its top module.
// Assumes link pins change slowly against clk, as the bench drives them.
`timescale 1ns/1ps
module spi_front_sva
    import spi_front_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic sel_n,
    input wire logic sclk,
    input wire logic sdo,
    input wire logic sdo_oe,
    input wire spi_front_pkg::cmd_report_t report,
    input wire logic cmd_valid,
    input wire logic addr_valid,
    input wire logic write_enable_flag,
    input wire logic mode3
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);

    // Pins pass two flops, so allow a few cycles after deselect.
    idle_quiet_a: assert property (sel_n [*6] |-> !sdo_oe)
        else $error("output enabled while deselected");
    sel_gate_a: assert property (cmd_valid |-> !$past(sel_n, 5))
        else $error("command decoded outside a frame");
    mode_pick_a: assert property ($fell(sel_n) |-> ##6 mode3 == $past(sclk, 6))
        else $error("mode does not follow clock level at select");
    read_oe_a: assert property ($rose(sdo_oe) |-> ##[0:2] report.cmd inside {CMD_STATUS_READ,
        CMD_MEM_READ, CMD_FAST_READ, CMD_SPECIAL_READ, CMD_DEVICE_ID_READ,
        CMD_UNIQUE_ID_READ, CMD_SERIAL_READ})
        else $error("output driven for a non-read command");
    opcode_ok_a: assert property (cmd_valid |-> report.cmd != CMD_NONE)
        else $error("valid pulse for an invalid opcode");
    addr_cmd_a: assert property (addr_valid |->
        report.cmd inside {CMD_MEM_WRITE, CMD_MEM_READ, CMD_FAST_READ})
        else $error("address taken for a command without one");
    flag_set_a: assert property (cmd_valid && report.cmd == CMD_LATCH_SET
        |-> ##[0:2] write_enable_flag)
        else $error("latch set opcode did not raise the flag");
    flag_clear_a: assert property ($rose(sel_n) && report.cmd inside {CMD_LATCH_CLEAR,
        CMD_STATUS_WRITE, CMD_MEM_WRITE, CMD_SPECIAL_WRITE, CMD_SERIAL_WRITE}
        |-> ##[1:8] !write_enable_flag)
        else $error("flag not cleared at end of write");
    // The clock stays low six cycles, so a change after a rise shows here.
    sdo_fall_a: assert property (sdo_oe && $past(sdo_oe) && $changed(sdo)
        |-> !$past(sclk, 2))
        else $error("output changed away from a falling clock");

    cover property (cmd_valid && report.cmd == CMD_STATUS_READ);
    cover property ($rose(mode3));
    cover property (addr_valid);
endmodule

bind spi_memory_slave_frontend spi_front_sva u_spi_front_sva (.*);

// file: test/spi_master_model.sv
// Master model that frames transfers on the link pins of the front end.
// Assumes the bench clock; pins change 1 ns after its rising edges.
`timescale 1ns/1ps
module spi_master_model (
    // Bench clock.
    input wire logic clk,
    // Link pins; miso is the resolved serial output wire.
    output logic sel_n,
    output logic sclk,
    output logic sdi,
    input wire logic miso
);
    // Deselected with the clock parked low at time zero.
    initial begin
        sel_n = 1'b1;
        sclk = 1'b0;
        sdi = 1'b0;
    end

    // Wait n cycles and step just past the edge.
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // One frame: low 48 ns, high 32 ns, so the output has time to settle.
    task automatic frame(input logic m3, input int nbits, input logic [39:0] tx,
        output logic [7:0] rx);
        sclk = m3;
        tick(6);
        sel_n = 1'b0;
        tick(6);
        for (int i = nbits - 1; i >= 0; i--) begin
            sclk = 1'b0;
            sdi = tx[i];
            tick(6);
            sclk = 1'b1;
            rx = {rx[6:0], miso};
            tick(4);
        end
        sclk = m3;
        tick(4);
        sel_n = 1'b1;
        // A released line must not keep showing its last bit.
        sdi = ~sdi;
        tick(4);
    endtask
endmodule

// file: test/spi_memory_slave_frontend_tb_top.sv
// Testbench for the serial memory front end against the master model.
// Assumes the checker binds itself to the design's top module.
`timescale 1ns/1ps
module spi_memory_slave_frontend_tb_top;
    import spi_front_pkg::*;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic sel_n, sclk, sdi, sdo, sdo_oe;
    logic cmd_valid, addr_valid, data_valid, write_enable_flag, mode3;
    wire miso;
    cmd_report_t report;
    logic [7:0] status_ext = 8'hFF;
    logic [7:0] rx;
    cmd_t last_cmd;
    int num_errors = 0;
    int checks_done = 0;
    int cmd_cnt = 0;
    int addr_cnt = 0;
    int data_cnt = 0;

    always #4 clk = ~clk;
    // A released line shows the inverse of the last bit, so a late sample shows up.
    assign miso = sdo_oe ? sdo : ~sdo;

    spi_memory_slave_frontend u_spi_memory_slave_frontend (.clk(clk), .nrst(nrst),
        .sel_n(sel_n), .sclk(sclk), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe),
        .report(report), .cmd_valid(cmd_valid), .addr_valid(addr_valid),
        .data_valid(data_valid), .status_ext(status_ext),
        .write_enable_flag(write_enable_flag), .mode3(mode3));
    spi_master_model u_spi_master_model (.clk(clk), .sel_n(sel_n), .sclk(sclk),
        .sdi(sdi), .miso(miso));

    // Pulses are one cycle, so count them here for the tasks to read.
    always @(posedge clk) begin
        if (cmd_valid === 1'b1) begin
            cmd_cnt++;
            last_cmd = report.cmd;
        end
        addr_cnt += int'(addr_valid === 1'b1);
        data_cnt += int'(data_valid === 1'b1);
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic send(input logic m3, input int n, input logic [39:0] tx);
        u_spi_master_model.frame(m3, n, tx, rx);
    endtask

    // Partial frame, all fifteen opcodes in alternating modes, then invalid ones.
    task automatic t_decode();
        logic [7:0] ops [15] = '{8'h06, 8'h04, 8'h05, 8'h01, 8'h02, 8'h03, 8'h0B,
            8'h42, 8'h4B, 8'h9F, 8'h4C, 8'hC2, 8'hC3, 8'hBA, 8'hB9};
        logic [7:0] bad [4] = '{8'h00, 8'h07, 8'h4A, 8'hFF};
        int n;
        n = cmd_cnt;
        send(1'b0, 5, 40'h1F);
        check(cmd_cnt - n, 0);
        for (int i = 0; i < 15; i++) begin
            n = cmd_cnt;
            send(i[0], 8, {32'h0, ops[i]});
            check(cmd_cnt - n, 1);
            check(last_cmd, i + 1);
        end
        for (int i = 0; i < 4; i++) begin
            n = cmd_cnt + addr_cnt + data_cnt;
            send(1'b0, 32, {bad[i], 24'h060500});
            check(cmd_cnt + addr_cnt + data_cnt - n, 0);
            check(write_enable_flag, 1'b0);
        end
    endtask

    // Latch set, status read, latch clear, status read in one mode.
    task automatic t_status(input logic m3);
        send(m3, 8, 40'h06);
        check(mode3, m3);
        check(write_enable_flag, 1'b1);
        // The master sends only zeros while the device answers, as on a shared line.
        send(m3, 16, 40'h0500);
        check(rx, 8'hCE);
        send(m3, 8, 40'h04);
        send(m3, 16, 40'h0500);
        check(rx, 8'hCC);
    endtask

    // Write with dirty upper address bits, then a fast read.
    task automatic t_addr();
        int a;
        int d;
        send(1'b0, 8, 40'h06);
        a = addr_cnt;
        d = data_cnt;
        send(1'b1, 40, 40'h02ABCDEF5A);
        check(addr_cnt - a, 1);
        check(report.addr, 19'h3CDEF);
        check(data_cnt - d, 1);
        check(report.data, 8'h5A);
        check(write_enable_flag, 1'b0);
        send(1'b0, 32, 40'h0B000123);
        check(report.addr, 19'h00123);
    endtask

    task automatic stop_test();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        repeat (2) @(posedge clk);
        #1;
        nrst = 1'b1;
        t_decode();
        t_status(1'b0);
        t_status(1'b1);
        t_addr();
        stop_test();
    end

    // The tests take some 40 us; this cuts a hang well after that.
    initial begin
        #400000;
        num_errors++;
        stop_test();
    end
endmodule
